// ### verilog/wsc_consts.svh
`ifndef WSC_CONSTS_SVH
`define WSC_CONSTS_SVH

`define WSC_REG_ADDR      16'hFFC2
`define WSC_RESET_VAL     8'hC8
`define WSC_FIXED_ONES    8'hC0
`define WSC_WRITE_MASK    8'h3F
`define WSC_HALVE_BIT     5
`define WSC_RSVD_BIT      4
`define WSC_MODE_MSB      3
`define WSC_MODE_LSB      2
`define WSC_COUNT_MSB     1
`define WSC_COUNT_LSB     0
`define WSC_MODE_PROG     2'h0
`define WSC_MODE_NONE     2'h1
`define WSC_MODE_PIN      2'h2
`define WSC_MODE_AUTO     2'h3

`endif

// ### verilog/wsc_pkg.sv
`default_nettype none

package wsc_pkg;

  typedef enum logic [2:0] {
    WSC_IDLE,
    WSC_T1,
    WSC_T2,
    WSC_TW,
    WSC_T3
  } wsc_state_t;

  typedef logic [1:0] wsc_mode_t;

endpackage

`default_nettype wire

// ### verilog/wsc_clk_halver.sv
`default_nettype none

// Produces the supporting-module clock as an enable, so no gated clock leaves the block.
module wsc_clk_halver (
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic halve_in,
  output logic      periph_clk_en_out
);

  logic phase;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase <= 1'b1;
    end else if (clk_en_in) begin
      phase <= halve_in ? ~phase : 1'b1;
    end
  end

  assign periph_clk_en_out = halve_in ? phase : 1'b1;

endmodule // wsc_clk_halver

`default_nettype wire

// ### verilog/wsc_bus_cycle_stretcher.sv
// Decided for this implementation: the address-and-strobe port.
`include "wsc_consts.svh"
`default_nettype none

// Functional notes
// - One 8-bit read/write wait-state control register sits at address FFC2.
// - The register loads C8 on reset and on hardware standby and keeps its value otherwise.
// - Bits 7 and 6 ignore writes and always read as one.
// - Bit 4 is a plain read/write bit that resets to zero and does nothing.
// - Bit 5 decides whether the supporting-module clock is divided.
// - Bit 5 at zero gives the undivided clock, at one the clock divided by two.
// - Bits 3:2 pick programmable, no-wait, pin wait or pin auto-wait mode.
// - Bits 1:0 give zero to three wait states for external accesses.
// - Programmable mode inserts exactly the wait count whatever the wait pin does.
// - Pin wait mode inserts the count, then adds a state if the pin is low in the last one.
// - Pin wait mode keeps adding states while the pin stays low.
// - Pin auto-wait mode inserts the count only if the pin is low during the second state.
// - Pin auto-wait mode never goes beyond the configured count.
module wsc_bus_cycle_stretcher (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        hw_standby_in,
  input  wire logic        cycle_start_in,
  input  wire logic        external_in,
  input  wire logic        wait_req_n_in,
  output logic             bus_busy_out,
  output logic             wait_state_out,
  output logic             cycle_end_out,
  output logic             periph_clk_en_out
);

  logic [7:0]          wait_state_control;
  logic                reg_hit;
  wsc_pkg::wsc_state_t state;
  wsc_pkg::wsc_state_t next_state;
  wsc_pkg::wsc_mode_t  cyc_mode;
  logic [1:0]          cyc_count;
  logic                cyc_ext;
  logic [1:0]          wait_left;
  logic [7:0]          tw_seen;
  logic                auto_low;

  assign reg_hit = (reg_addr_in == `WSC_REG_ADDR);

  // Software standby has no input here on purpose: the register simply keeps its value.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_state_control <= `WSC_RESET_VAL;
    end else if (clk_en_in) begin
      if (hw_standby_in) begin
        wait_state_control <= `WSC_RESET_VAL;
      end else if (reg_wr_in && reg_hit) begin
        wait_state_control <= (reg_wdata_in & `WSC_WRITE_MASK) | `WSC_FIXED_ONES;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      reg_rdata_out <= (reg_rd_in && reg_hit) ? wait_state_control : 8'h00;
    end
  end

  wsc_clk_halver u_halver (
    .core_clk_in       (core_clk_in),
    .reset_n_in        (reset_n_in),
    .clk_en_in         (clk_en_in),
    .halve_in          (wait_state_control[`WSC_HALVE_BIT]),
    .periph_clk_en_out (periph_clk_en_out)
  );

  // Mode and count are frozen per bus cycle so a register write cannot tear a cycle.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_mode  <= `WSC_MODE_NONE;
      cyc_count <= 2'h0;
      cyc_ext   <= 1'b0;
    end else if (clk_en_in && cycle_start_in &&
                 (state == wsc_pkg::WSC_IDLE || state == wsc_pkg::WSC_T3)) begin
      cyc_mode  <= wait_state_control[`WSC_MODE_MSB:`WSC_MODE_LSB];
      cyc_count <= wait_state_control[`WSC_COUNT_MSB:`WSC_COUNT_LSB];
      cyc_ext   <= external_in;
    end
  end

  // The wait pin is sampled at the edge that ends the state, which stands in for the
  // falling edge of the system clock inside that state.
  always_comb begin
    next_state = state;
    case (state)
      wsc_pkg::WSC_IDLE: begin
        if (cycle_start_in) begin
          next_state = wsc_pkg::WSC_T1;
        end
      end
      wsc_pkg::WSC_T1: begin
        next_state = wsc_pkg::WSC_T2;
      end
      wsc_pkg::WSC_T2: begin
        next_state = wsc_pkg::WSC_T3;
        if (cyc_ext) begin
          case (cyc_mode)
            `WSC_MODE_PROG: begin
              if (cyc_count != 2'h0) begin
                next_state = wsc_pkg::WSC_TW;
              end
            end
            `WSC_MODE_PIN: begin
              if (cyc_count != 2'h0 || !wait_req_n_in) begin
                next_state = wsc_pkg::WSC_TW;
              end
            end
            `WSC_MODE_AUTO: begin
              if (cyc_count != 2'h0 && !wait_req_n_in) begin
                next_state = wsc_pkg::WSC_TW;
              end
            end
            default: begin
              next_state = wsc_pkg::WSC_T3;
            end
          endcase
        end
      end
      wsc_pkg::WSC_TW: begin
        if (wait_left != 2'h0) begin
          next_state = wsc_pkg::WSC_TW;
        end else if (cyc_mode == `WSC_MODE_PIN && !wait_req_n_in) begin
          next_state = wsc_pkg::WSC_TW;
        end else begin
          next_state = wsc_pkg::WSC_T3;
        end
      end
      wsc_pkg::WSC_T3: begin
        next_state = cycle_start_in ? wsc_pkg::WSC_T1 : wsc_pkg::WSC_IDLE;
      end
      default: begin
        next_state = wsc_pkg::WSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= wsc_pkg::WSC_IDLE;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_left <= 2'h0;
    end else if (clk_en_in) begin
      if (state == wsc_pkg::WSC_T2) begin
        wait_left <= (cyc_count == 2'h0) ? 2'h0 : cyc_count - 2'h1;
      end else if (state == wsc_pkg::WSC_TW && wait_left != 2'h0) begin
        wait_left <= wait_left - 2'h1;
      end
    end
  end

  assign bus_busy_out   = (state != wsc_pkg::WSC_IDLE);
  assign wait_state_out = (state == wsc_pkg::WSC_TW);
  assign cycle_end_out  = (state == wsc_pkg::WSC_T3);

  // Helper logic read only by the checks below.
  // Saturating the count keeps a stuck wait pin from wrapping it into a legal-looking value.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tw_seen  <= 8'h00;
      auto_low <= 1'b0;
    end else if (clk_en_in) begin
      if (state == wsc_pkg::WSC_T1) begin
        tw_seen <= 8'h00;
      end else if (state == wsc_pkg::WSC_TW && tw_seen != 8'hFF) begin
        tw_seen <= tw_seen + 8'h01;
      end
      if (state == wsc_pkg::WSC_T2) begin
        auto_low <= !wait_req_n_in;
      end
    end
  end

  default clocking cb @(posedge core_clk_in iff clk_en_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_fixed_ones;
    reg_rd_in && reg_hit |=> reg_rdata_out[7:6] == 2'h3 && reg_rdata_out[4] ==
      $past(wait_state_control[4]);
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("bits 7:6 not read as one");

  property p_standby_init;
    hw_standby_in |=> wait_state_control == 8'hC8;
  endproperty
  a_standby_init: assert property (p_standby_init) else $error("standby did not init");

  property p_rsvd_rw;
    reg_wr_in && reg_hit && !hw_standby_in |=> wait_state_control[5:0] == $past(reg_wdata_in[5:0]);
  endproperty
  a_rsvd_rw: assert property (p_rsvd_rw) else $error("register write lost");

  property p_prog_exact;
    state == wsc_pkg::WSC_T3 && cyc_ext && cyc_mode == 2'h0 |-> tw_seen == {6'h00, cyc_count};
  endproperty
  a_prog_exact: assert property (p_prog_exact) else $error("programmable count wrong");

  property p_auto_count;
    state == wsc_pkg::WSC_T3 && cyc_ext && cyc_mode == 2'h3 |->
      tw_seen == (auto_low ? {6'h00, cyc_count} : 8'h00);
  endproperty
  a_auto_count: assert property (p_auto_count) else $error("auto-wait count wrong");

  property p_pin_extend;
    state == wsc_pkg::WSC_TW && wait_left == 2'h0 && cyc_mode == 2'h2 && !wait_req_n_in
      |=> state == wsc_pkg::WSC_TW;
  endproperty
  a_pin_extend: assert property (p_pin_extend) else $error("pin wait not extended");

  property p_pin_min;
    state == wsc_pkg::WSC_T3 && cyc_ext && cyc_mode == 2'h2 |-> tw_seen >= {6'h00, cyc_count};
  endproperty
  a_pin_min: assert property (p_pin_min) else $error("pin wait too short");

  property p_no_stretch;
    state == wsc_pkg::WSC_T3 && (!cyc_ext || cyc_mode == 2'h1) |-> tw_seen == 8'h00;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("cycle stretched");

  property p_tw_place;
    state == wsc_pkg::WSC_TW |-> $past(state) == wsc_pkg::WSC_T2 ||
      $past(state) == wsc_pkg::WSC_TW;
  endproperty
  a_tw_place: assert property (p_tw_place) else $error("wait state misplaced");

  property p_halve_off;
    !wait_state_control[5] |-> periph_clk_en_out ##1 (wait_state_control[5] || periph_clk_en_out);
  endproperty
  a_halve_off: assert property (p_halve_off) else $error("peripheral clock divided");

  property p_halve_on;
    wait_state_control[5] && $past(wait_state_control[5]) |->
      periph_clk_en_out != $past(periph_clk_en_out);
  endproperty
  a_halve_on: assert property (p_halve_on) else $error("peripheral clock not divided");

  property p_rdata_idle;
    !(reg_rd_in && reg_hit) |=> reg_rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

  property p_t1_next;
    state == wsc_pkg::WSC_T1 |=> state == wsc_pkg::WSC_T2;
  endproperty
  a_t1_next: assert property (p_t1_next) else $error("second state skipped");

  property p_int_short;
    state == wsc_pkg::WSC_T2 && !cyc_ext |=> state == wsc_pkg::WSC_T3;
  endproperty
  a_int_short: assert property (p_int_short) else $error("internal stretched");

  property p_end_one;
    state == wsc_pkg::WSC_T3 && !cycle_start_in |=> state == wsc_pkg::WSC_IDLE;
  endproperty
  a_end_one: assert property (p_end_one) else $error("last state repeated");

  property p_prog_fixed;
    state == wsc_pkg::WSC_TW && wait_left == 2'h0 && cyc_mode == 2'h0
      |=> state == wsc_pkg::WSC_T3;
  endproperty
  a_prog_fixed: assert property (p_prog_fixed) else $error("prog wait stretched");

  property p_pin_release;
    state == wsc_pkg::WSC_TW && wait_left == 2'h0 && cyc_mode == 2'h2 && wait_req_n_in
      |=> state == wsc_pkg::WSC_T3;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin wait not released");

  property p_auto_cap;
    state == wsc_pkg::WSC_TW && cyc_mode == 2'h3 |-> tw_seen < {6'h00, cyc_count};
  endproperty
  a_auto_cap: assert property (p_auto_cap) else $error("auto-wait overran");

  property p_auto_skip;
    state == wsc_pkg::WSC_T2 && cyc_ext && cyc_mode == 2'h3 && wait_req_n_in
      |=> state == wsc_pkg::WSC_T3;
  endproperty
  a_auto_skip: assert property (p_auto_skip) else $error("auto-wait without request");

  c_prog_two: cover property (state == wsc_pkg::WSC_T3 && cyc_mode == 2'h0 && tw_seen == 8'h02);
  c_pin_extra: cover property (state == wsc_pkg::WSC_T3 && cyc_mode == 2'h2 &&
    tw_seen > {6'h00, cyc_count});
  c_auto_hit: cover property (state == wsc_pkg::WSC_T3 && cyc_mode == 2'h3 && tw_seen != 8'h00);
  c_halved: cover property (wait_state_control[5] ##1 !periph_clk_en_out);
  c_internal: cover property (state == wsc_pkg::WSC_T3 && !cyc_ext);

endmodule // wsc_bus_cycle_stretcher

`default_nettype wire

// ### verif/wsc_ext_dev_model.sv
`default_nettype none

// Slow external device: requests waits while its access is younger than hold_in states.
module wsc_ext_dev_model (
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       selected_in,
  input  wire logic       bus_busy_in,
  input  wire logic [3:0] hold_in,
  output logic            wait_req_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] age;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      age <= 4'h0;
    end else if (bus_busy_in) begin
      age <= age + 4'h1;
    end else begin
      age <= 4'h0;
    end
  end
  // The pin is pulled up, so outside its own access the device never shows a request.
  assign wait_req_n_out = !(selected_in && bus_busy_in && (age < hold_in));
endmodule // wsc_ext_dev_model

`default_nettype wire

// ### verif/wsc_bus_cycle_stretcher_tb.sv
`default_nettype none

module wsc_bus_cycle_stretcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        hw_standby = 1'b0;
  logic        start = 1'b0;
  logic        ext = 1'b0;
  logic [3:0]  hold = 4'h0;
  logic [7:0]  rdata;
  logic        wait_n;
  logic        busy;
  logic        wait_state;
  logic        cycle_end;
  logic        pclk_en;
  int          fails = 0;
  int          check_count = 0;

  always #12.5 core_clk = ~core_clk;

  wsc_bus_cycle_stretcher wsc_bus_cycle_stretcher_inst (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .clk_en_in(clk_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .hw_standby_in(hw_standby), .cycle_start_in(start),
    .external_in(ext), .wait_req_n_in(wait_n), .bus_busy_out(busy),
    .wait_state_out(wait_state), .cycle_end_out(cycle_end), .periph_clk_en_out(pclk_en));

  wsc_ext_dev_model wsc_ext_dev_model_inst (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .selected_in(ext),
    .bus_busy_in(busy), .hold_in(hold), .wait_req_n_out(wait_n));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask

  task automatic test_map();
    logic [7:0] d;
    reg_read(16'hFFC2, d);
    check("reset value", d, 8'hC8);
    reg_write(16'hFFC3, 8'h3F);
    reg_read(16'hFFC3, d);
    check("unmapped read", d, 8'h00);
    reg_read(16'hFFC2, d);
    check("after unmapped write", d, 8'hC8);
  endtask

  task automatic test_bits();
    logic [7:0] d;
    reg_write(16'hFFC2, 8'h3F);
    reg_read(16'hFFC2, d);
    check("all ones", d, 8'hFF);
    reg_write(16'hFFC2, 8'h00);
    reg_read(16'hFFC2, d);
    check("all zeros", d, 8'hC0);
    reg_write(16'hFFC2, 8'h10);
    reg_read(16'hFFC2, d);
    check("spare bit", d, 8'hD0);
  endtask

  task automatic test_standby();
    logic [7:0] d;
    reg_write(16'hFFC2, 8'h3F);
    @(posedge core_clk);
    hw_standby <= 1'b1;
    @(posedge core_clk);
    hw_standby <= 1'b0;
    reg_read(16'hFFC2, d);
    check("standby value", d, 8'hC8);
  endtask

  task automatic test_reset();
    logic [7:0] d;
    reg_write(16'hFFC2, 8'h3F);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(negedge core_clk);
    check("reset clock enable", {7'h00, pclk_en}, 8'h01);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    reg_read(16'hFFC2, d);
    check("reset value again", d, 8'hC8);
  endtask

  task automatic test_freeze();
    logic [7:0] d;
    logic       held;
    reg_write(16'hFFC2, 8'h25);
    @(posedge core_clk);
    clk_en <= 1'b0;
    reg_write(16'hFFC2, 8'h00);
    @(negedge core_clk);
    held = pclk_en;
    @(negedge core_clk);
    check("frozen clock enable", {7'h00, pclk_en}, {7'h00, held});
    @(posedge core_clk);
    clk_en <= 1'b1;
    reg_read(16'hFFC2, d);
    check("frozen write", d, 8'hE5);
  endtask

  task automatic test_halve(input logic [7:0] v);
    logic prev;
    reg_write(16'hFFC2, v);
    @(negedge core_clk);
    @(negedge core_clk);
    prev = pclk_en;
    repeat (4) begin
      @(negedge core_clk);
      check("module clock enable", {7'h00, pclk_en}, {7'h00, v[5] ? ~prev : 1'b1});
      prev = pclk_en;
    end
  endtask

  function automatic int exp_waits(input int m, input int c, input int h, input bit e);
    if (!e || m == 1) return 0;
    if (m == 0) return c;
    if (m == 2) return (h - 1 > c) ? h - 1 : c;
    return (h >= 2) ? c : 0;
  endfunction

  task automatic run_cycle(input int m, input int c, input int h, input bit e);
    int len;
    int waits;
    int n;
    reg_write(16'hFFC2, {4'h0, m[1:0], c[1:0]});
    hold <= h[3:0];
    ext <= e;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    len = 0;
    waits = 0;
    n = exp_waits(m, c, h, e);
    while (len < 40) begin
      @(negedge core_clk);
      len++;
      check("busy", {7'h00, busy}, 8'h01);
      if (wait_state === 1'b1) waits++;
      if (cycle_end === 1'b1) break;
    end
    @(posedge core_clk);
    ext <= 1'b0;
    @(negedge core_clk);
    check("idle", {7'h00, busy}, 8'h00);
    check("wait states", waits[7:0], n[7:0]);
    check("cycle length", len[7:0], 8'(n + 3));
  endtask

  task automatic test_waits();
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < 3; k++) begin
          run_cycle(m, c, 3 * k, 1'b1);
        end
      end
    end
    run_cycle(2, 3, 6, 1'b0);
  endtask

  task automatic close_out();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    test_map();
    test_bits();
    test_standby();
    test_reset();
    test_freeze();
    test_halve(8'h00);
    test_halve(8'h20);
    test_waits();
    close_out();
  end

  // Whole run needs under two thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    close_out();
  end
endmodule // wsc_bus_cycle_stretcher_tb

`default_nettype wire
